// ### include/vsync_pkg.sv
package vsync_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_SYNC_CFG   = 8'h6B;
	localparam logic [7:0] IDX_HORIZ_TRIGGER_PHASE_LO   = 8'h6C;
	localparam logic [7:0] IDX_TRIG_HI    = 8'h6D;
	localparam logic [7:0] IDX_VIDEO_MODE = 8'h70;
	localparam logic [7:0] IDX_REF_START  = 8'h71;
	localparam logic [7:0] IDX_REF_STOP   = 8'h72;
	localparam logic [7:0] IDX_FIRST_LINE = 8'h73;
	localparam logic [7:0] IDX_LAST_LINE  = 8'h74;
	localparam logic [7:0] IDX_STATUS     = 8'h75;

	localparam int ADDR_W  = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// field positions
	localparam int HORIZ_TRIGGER_PHASE_HI_LSB = 5;
	localparam int HORIZ_TRIGGER_PHASE_HI_MSB = 7;
	localparam int VERT_TRIGGER_PHASE_MSB    = 4;
	localparam int STAT_V_LSB   = 16;

	// reset values
	localparam logic [7:0]  SYNC_CFG_RST   = 8'h00;
	localparam logic [10:0] HORIZ_TRIGGER_PHASE_RST      = 11'h000;
	localparam logic [4:0]  VERT_TRIGGER_PHASE_RST      = 5'h00;
	localparam logic [3:0]  VIDEO_MODE_RST = 4'h0;
	localparam logic [10:0] REF_START_RST  = 11'h106;
	localparam logic [10:0] REF_STOP_RST   = 11'h6A6;
	localparam logic [8:0]  FIRST_LINE_RST = 9'h017;
	localparam logic [8:0]  LAST_LINE_RST  = 9'h136;

	// horizontal counter runs in half pixel units, two per clock
	localparam logic [11:0] H_STEP      = 12'h002;
	localparam logic [10:0] H_MAX_864   = 11'h6BF;
	localparam logic [10:0] H_MAX_858   = 11'h6B3;
	localparam logic [10:0] H_HALF_864  = 11'h360;
	localparam logic [10:0] H_HALF_858  = 11'h35A;
	localparam logic [10:0] HS_START    = 11'h04F;
	localparam logic [10:0] HS_END      = 11'h0CD;

	// vertical counter runs in half lines
	localparam logic [10:0] FRAME_HALF_625 = 11'h4E2;
	localparam logic [10:0] FRAME_HALF_525 = 11'h41A;
	localparam logic [10:0] FIELD_HALF_625 = 11'h271;
	localparam logic [10:0] FIELD_HALF_525 = 11'h20D;
	localparam logic [10:0] VS_HALF_LINES  = 11'h006;

	localparam logic [3:0] FIELD_SEQ_SYNC_NTSC  = 4'h4;
	localparam logic [3:0] FIELD_SEQ_SYNC_PAL   = 4'h8;
	localparam logic [3:0] FIELD_SEQ_SYNC_SECAM = 4'hC;

	typedef enum logic [1:0] {
		PIN_A_VSYNC = 2'h0,
		PIN_A_FRAME = 2'h1,
		PIN_A_FIELD_SEQ_SYNC  = 2'h2,
		PIN_A_NONE  = 2'h3
	} pin_a_type_t;

	typedef struct packed {
		pin_a_type_t pin_a_type;
		logic        hsync_source_sel;
		logic        pin_a_dir;
		logic        pin_a_pol;
		logic        blank_flag_mode;
		logic        pin_b_dir;
		logic        pin_b_pol;
	} sync_cfg_t;

	typedef struct packed {
		logic secam;
		logic pal;
		logic stream_sync_mode;
		logic line_length_sel;
	} video_mode_t;

endpackage

// ### src/sync_edge_detect.sv
`timescale 1ns/1ps
module sync_edge_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_i,
	input  wire logic pol_low,
	output logic      level,
	output logic      edge_pulse
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic prev_q, prev_d;

	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// polarity folds falling edges into the same active edge
	assign level      = sync_q ^ pol_low;
	assign edge_pulse = (sync_q ^ pol_low) & ~(prev_q ^ pol_low);
endmodule // sync_edge_detect

// ### src/video_sync_port_trigger.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - two-bit type selects pin A signal
// - field sequence every 4, 8, 12 fields
// - source select picks horizontal sync origin
// - pin A direction: 0 input, 1 output
// - pin A polarity for drive and edge
// - pin B drives reference pulse incl. vblank
// - pin B input used only for hsync
// - pin B drives blanking-not, vblank suppressed
// - pin B input gives hsync and blanking
// - pin B direction: 0 input, 1 output
// - pin B polarity for drive and edge
// - 11-bit trigger phase across two registers
// - larger phase shortens internal timing delay
// - phase 79 aligns hsync with trigger edge
// - line length select: 864 or 858
// - high phase bits 7..5, vertical phase below
// - vertical phase in half lines loads counter
module video_sync_port_trigger (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [vsync_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [vsync_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        sync_pin_a_i,
	output logic                             sync_pin_a_o,
	output logic                             sync_pin_a_oe,
	input  wire logic                        sync_pin_b_i,
	output logic                             sync_pin_b_o,
	output logic                             sync_pin_b_oe,
	input  wire logic                        stream_hsync,
	input  wire logic                        stream_vsync,
	output logic                             hsync_out,
	output logic                             blank_out,
	output logic                             odd_field_out
);
	function automatic logic [10:0] wr11(input logic [10:0] old, input logic [31:0] d,
		input logic [3:0] s);
		wr11 = {s[1] ? d[10:8] : old[10:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [8:0] wr9(input logic [8:0] old, input logic [31:0] d,
		input logic [3:0] s);
		wr9 = {s[1] ? d[8] : old[8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	vsync_pkg::sync_cfg_t   cfg_q, cfg_d;
	vsync_pkg::video_mode_t mode_q, mode_d;
	logic [10:0] horiz_trigger_phase_q, horiz_trigger_phase_d;
	logic [4:0]  vert_trigger_phase_q, vert_trigger_phase_d;
	logic [10:0] ref_start_q, ref_start_d, ref_stop_q, ref_stop_d;
	logic [8:0]  fal_q, fal_d, lal_q, lal_d;

	logic                        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [vsync_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0]                 wdata_q, wdata_d;
	logic [3:0]                  wstrb_q, wstrb_d;
	logic                        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]                  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]                 rdata_q, rdata_d;
	logic                        aw_have, w_have, do_write;
	logic [vsync_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0]                 wr_data;
	logic [3:0]                  wr_strb;
	logic [7:0]                  wr_idx, rd_idx;

	logic [10:0] hcnt_q, hcnt_d, vhalf_q, vhalf_d;
	logic [3:0]  field_seq_sync_q, field_seq_sync_d;
	logic        pin_a_o_q, pin_a_o_d, pin_b_o_q, pin_b_o_d;
	logic        hsync_q, hsync_d, blank_q, blank_d, odd_q, odd_d;
	logic        a_level, a_edge, b_level, b_edge;
	logic        h_trig, v_trig, half_tick, field_tick;
	logic [10:0] h_max, h_half, frame_half, field_half, fpos;
	logic [11:0] h_step;
	logic [3:0]  field_seq_sync_period;
	logic [9:0]  line_in_field;
	logic        active_line, vs_now, horiz_ref_pulse;

	sync_edge_detect u_edge_a (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_i      (sync_pin_a_i),
		.pol_low    (cfg_q.pin_a_pol),
		.level      (a_level),
		.edge_pulse (a_edge)
	);

	sync_edge_detect u_edge_b (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_i      (sync_pin_b_i),
		.pol_low    (cfg_q.pin_b_pol),
		.level      (b_level),
		.edge_pulse (b_edge)
	);

	// register slave: address and data may arrive in either order
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign aw_have  = aw_hold_q || (s_axi_awvalid && s_axi_awready);
	assign w_have   = w_hold_q || (s_axi_wvalid && s_axi_wready);
	assign do_write = aw_have && w_have && !bvalid_q;
	assign wr_addr  = aw_hold_q ? awaddr_q : s_axi_awaddr;
	assign wr_data  = w_hold_q ? wdata_q : s_axi_wdata;
	assign wr_strb  = w_hold_q ? wstrb_q : s_axi_wstrb;
	assign wr_idx   = wr_addr[vsync_pkg::IDX_MSB:vsync_pkg::IDX_LSB];
	assign rd_idx   = s_axi_araddr[vsync_pkg::IDX_MSB:vsync_pkg::IDX_LSB];

	always_comb begin
		aw_hold_d   = do_write ? 1'b0 : aw_have;
		w_hold_d    = do_write ? 1'b0 : w_have;
		awaddr_d    = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
		wdata_d     = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
		wstrb_d     = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
		bvalid_d    = bvalid_q && !s_axi_bready;
		bresp_d     = bresp_q;
		cfg_d       = cfg_q;
		mode_d      = mode_q;
		horiz_trigger_phase_d     = horiz_trigger_phase_q;
		vert_trigger_phase_d     = vert_trigger_phase_q;
		ref_start_d = ref_start_q;
		ref_stop_d  = ref_stop_q;
		fal_d       = fal_q;
		lal_d       = lal_q;
		if (do_write) begin
			bvalid_d = 1'b1;
			bresp_d  = vsync_pkg::RESP_OKAY;
			unique case (wr_idx)
				vsync_pkg::IDX_SYNC_CFG: begin
					if (wr_strb[0]) cfg_d = vsync_pkg::sync_cfg_t'(wr_data[7:0]);
				end
				vsync_pkg::IDX_HORIZ_TRIGGER_PHASE_LO: begin
					if (wr_strb[0]) horiz_trigger_phase_d[7:0] = wr_data[7:0];
				end
				vsync_pkg::IDX_TRIG_HI: begin
					if (wr_strb[0]) begin
						horiz_trigger_phase_d[10:8] = wr_data[vsync_pkg::HORIZ_TRIGGER_PHASE_HI_MSB:vsync_pkg::HORIZ_TRIGGER_PHASE_HI_LSB];
						vert_trigger_phase_d       = wr_data[vsync_pkg::VERT_TRIGGER_PHASE_MSB:0];
					end
				end
				vsync_pkg::IDX_VIDEO_MODE: begin
					if (wr_strb[0]) mode_d = vsync_pkg::video_mode_t'(wr_data[3:0]);
				end
				vsync_pkg::IDX_REF_START: ref_start_d = wr11(ref_start_q, wr_data, wr_strb);
				vsync_pkg::IDX_REF_STOP:  ref_stop_d  = wr11(ref_stop_q, wr_data, wr_strb);
				vsync_pkg::IDX_FIRST_LINE: fal_d = wr9(fal_q, wr_data, wr_strb);
				vsync_pkg::IDX_LAST_LINE:  lal_d = wr9(lal_q, wr_data, wr_strb);
				vsync_pkg::IDX_STATUS: ;
				default: bresp_d = vsync_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_comb begin
		rvalid_d = rvalid_q && !s_axi_rready;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = vsync_pkg::RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			unique case (rd_idx)
				vsync_pkg::IDX_SYNC_CFG:   rdata_d[7:0] = cfg_q;
				vsync_pkg::IDX_HORIZ_TRIGGER_PHASE_LO:   rdata_d[7:0] = horiz_trigger_phase_q[7:0];
				vsync_pkg::IDX_TRIG_HI:    rdata_d[7:0] = {horiz_trigger_phase_q[10:8], vert_trigger_phase_q};
				vsync_pkg::IDX_VIDEO_MODE: rdata_d[3:0] = mode_q;
				vsync_pkg::IDX_REF_START:  rdata_d[10:0] = ref_start_q;
				vsync_pkg::IDX_REF_STOP:   rdata_d[10:0] = ref_stop_q;
				vsync_pkg::IDX_FIRST_LINE: rdata_d[8:0] = fal_q;
				vsync_pkg::IDX_LAST_LINE:  rdata_d[8:0] = lal_q;
				vsync_pkg::IDX_STATUS: begin
					rdata_d[10:0] = hcnt_q;
					rdata_d[vsync_pkg::STAT_V_LSB +: 11] = vhalf_q;
				end
				default: rresp_d = vsync_pkg::RESP_SLVERR;
			endcase
		end
	end

	// timing generator
	always_comb begin
		h_max      = mode_q.line_length_sel ? vsync_pkg::H_MAX_858 : vsync_pkg::H_MAX_864;
		h_half     = mode_q.line_length_sel ? vsync_pkg::H_HALF_858 : vsync_pkg::H_HALF_864;
		frame_half = mode_q.line_length_sel ? vsync_pkg::FRAME_HALF_525 : vsync_pkg::FRAME_HALF_625;
		field_half = mode_q.line_length_sel ? vsync_pkg::FIELD_HALF_525 : vsync_pkg::FIELD_HALF_625;
		field_seq_sync_period = mode_q.secam ? vsync_pkg::FIELD_SEQ_SYNC_SECAM :
			(mode_q.pal ? vsync_pkg::FIELD_SEQ_SYNC_PAL : vsync_pkg::FIELD_SEQ_SYNC_NTSC);
		if (!cfg_q.hsync_source_sel) begin
			h_trig = mode_q.stream_sync_mode ? stream_hsync : (a_edge && !cfg_q.pin_a_dir);
		end else begin
			h_trig = b_edge && !cfg_q.pin_b_dir && !mode_q.stream_sync_mode;
		end
		v_trig = mode_q.stream_sync_mode ? stream_vsync : (a_edge && !cfg_q.pin_a_dir);
		h_step = {1'b0, hcnt_q} + vsync_pkg::H_STEP;
		if (h_step > {1'b0, h_max}) begin
			h_step = h_step - {1'b0, h_max} - 12'h001;
		end
		// a larger phase sits nearer the wrap, so every timing edge comes sooner
		hcnt_d = h_trig ? horiz_trigger_phase_q : h_step[10:0];
		half_tick = !h_trig && ((hcnt_q < h_half && h_step[10:0] >= h_half)
			|| h_step[10:0] < hcnt_q);
		if (v_trig) begin
			vhalf_d = {6'h00, vert_trigger_phase_q};
		end else if (half_tick) begin
			vhalf_d = (vhalf_q == frame_half - 11'h001) ? 11'h000 : vhalf_q + 11'h001;
		end else begin
			vhalf_d = vhalf_q;
		end
		field_tick = half_tick && (vhalf_d == 11'h000 || vhalf_d == field_half);
		if (field_tick) begin
			field_seq_sync_d = (field_seq_sync_q >= field_seq_sync_period - 4'h1) ? 4'h0 : field_seq_sync_q + 4'h1;
		end else begin
			field_seq_sync_d = field_seq_sync_q;
		end
		fpos          = (vhalf_d >= field_half) ? vhalf_d - field_half : vhalf_d;
		line_in_field = fpos[10:1];
		active_line   = line_in_field >= {1'b0, fal_q} && line_in_field <= {1'b0, lal_q};
		vs_now        = fpos < vsync_pkg::VS_HALF_LINES;
		odd_d         = vhalf_d < field_half;
		hsync_d       = hcnt_d >= vsync_pkg::HS_START && hcnt_d < vsync_pkg::HS_END;
		horiz_ref_pulse          = hcnt_d >= ref_start_q && hcnt_d < ref_stop_q;
		unique case (cfg_q.pin_a_type)
			vsync_pkg::PIN_A_VSYNC: pin_a_o_d = vs_now;
			vsync_pkg::PIN_A_FRAME: pin_a_o_d = odd_d;
			vsync_pkg::PIN_A_FIELD_SEQ_SYNC:  pin_a_o_d = vs_now && field_seq_sync_d == 4'h0;
			vsync_pkg::PIN_A_NONE:  pin_a_o_d = 1'b0;
		endcase
		pin_a_o_d = pin_a_o_d ^ cfg_q.pin_a_pol;
		pin_b_o_d = (cfg_q.blank_flag_mode ? (horiz_ref_pulse && active_line) : horiz_ref_pulse) ^ cfg_q.pin_b_pol;
		if (cfg_q.blank_flag_mode && !cfg_q.pin_b_dir && !mode_q.stream_sync_mode) begin
			blank_d = !b_level;
		end else begin
			blank_d = !(horiz_ref_pulse && active_line);
		end
	end

	assign sync_pin_a_oe = cfg_q.pin_a_dir;
	assign sync_pin_b_oe = cfg_q.pin_b_dir;
	assign sync_pin_a_o  = pin_a_o_q;
	assign sync_pin_b_o  = pin_b_o_q;
	assign hsync_out     = hsync_q;
	assign blank_out     = blank_q;
	assign odd_field_out = odd_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q       <= vsync_pkg::sync_cfg_t'(vsync_pkg::SYNC_CFG_RST);
			mode_q      <= vsync_pkg::video_mode_t'(vsync_pkg::VIDEO_MODE_RST);
			horiz_trigger_phase_q     <= vsync_pkg::HORIZ_TRIGGER_PHASE_RST;
			vert_trigger_phase_q     <= vsync_pkg::VERT_TRIGGER_PHASE_RST;
			ref_start_q <= vsync_pkg::REF_START_RST;
			ref_stop_q  <= vsync_pkg::REF_STOP_RST;
			fal_q       <= vsync_pkg::FIRST_LINE_RST;
			lal_q       <= vsync_pkg::LAST_LINE_RST;
			aw_hold_q   <= 1'b0;
			w_hold_q    <= 1'b0;
			awaddr_q    <= '0;
			wdata_q     <= 32'h0000_0000;
			wstrb_q     <= 4'h0;
			bvalid_q    <= 1'b0;
			bresp_q     <= vsync_pkg::RESP_OKAY;
			rvalid_q    <= 1'b0;
			rresp_q     <= vsync_pkg::RESP_OKAY;
			rdata_q     <= 32'h0000_0000;
			hcnt_q      <= 11'h000;
			vhalf_q     <= 11'h000;
			field_seq_sync_q      <= 4'h0;
			pin_a_o_q   <= 1'b0;
			pin_b_o_q   <= 1'b0;
			hsync_q     <= 1'b0;
			blank_q     <= 1'b1;
			odd_q       <= 1'b1;
		end else begin
			cfg_q       <= cfg_d;
			mode_q      <= mode_d;
			horiz_trigger_phase_q     <= horiz_trigger_phase_d;
			vert_trigger_phase_q     <= vert_trigger_phase_d;
			ref_start_q <= ref_start_d;
			ref_stop_q  <= ref_stop_d;
			fal_q       <= fal_d;
			lal_q       <= lal_d;
			aw_hold_q   <= aw_hold_d;
			w_hold_q    <= w_hold_d;
			awaddr_q    <= awaddr_d;
			wdata_q     <= wdata_d;
			wstrb_q     <= wstrb_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			rvalid_q    <= rvalid_d;
			rresp_q     <= rresp_d;
			rdata_q     <= rdata_d;
			hcnt_q      <= hcnt_d;
			vhalf_q     <= vhalf_d;
			field_seq_sync_q      <= field_seq_sync_d;
			pin_a_o_q   <= pin_a_o_d;
			pin_b_o_q   <= pin_b_o_d;
			hsync_q     <= hsync_d;
			blank_q     <= blank_d;
			odd_q       <= odd_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_h_load;
		h_trig ##1 (hcnt_q == $past(horiz_trigger_phase_q));
	endsequence

	property p_h_load;
		h_trig |-> s_h_load;
	endproperty
	a_h_load: assert property (p_h_load) else $error("trigger did not load phase");

	property p_phase79;
		(h_trig && horiz_trigger_phase_q == 11'h04F) |=> hsync_out && hcnt_q == 11'h04F;
	endproperty
	a_phase79: assert property (p_phase79) else $error("hsync not aligned at 79");

	property p_h_advance;
		(!h_trig && hcnt_q + 11'h002 <= h_max && $stable(mode_q)) |=>
			hcnt_q == $past(hcnt_q) + 11'h002;
	endproperty
	a_h_advance: assert property (p_h_advance) else $error("counter step wrong");

	property p_h_wrap;
		(!h_trig && hcnt_q == h_max) |=> hcnt_q == 11'h001;
	endproperty
	a_h_wrap: assert property (p_h_wrap) else $error("line length wrap wrong");

	property p_v_load;
		v_trig |=> vhalf_q == {6'h00, $past(vert_trigger_phase_q)};
	endproperty
	a_v_load: assert property (p_v_load) else $error("vertical phase not loaded");

	property p_a_dir;
		sync_pin_a_oe == cfg_q.pin_a_dir && (cfg_q.pin_a_dir || !a_edge || mode_q.stream_sync_mode
			|| v_trig);
	endproperty
	a_a_dir: assert property (p_a_dir) else $error("pin A direction wrong");

	property p_b_input_only;
		(cfg_q.pin_b_dir || !cfg_q.hsync_source_sel) |-> !(h_trig && b_edge && !a_edge
			&& !stream_hsync);
	endproperty
	a_b_input_only: assert property (p_b_input_only) else $error("pin B misused");

	property p_none_type;
		(cfg_q.pin_a_type == vsync_pkg::PIN_A_NONE && $stable(cfg_q)) |=>
			sync_pin_a_o == $past(cfg_q.pin_a_pol);
	endproperty
	a_none_type: assert property (p_none_type) else $error("pin A type 3 active");

	property p_cbn_vblank;
		(cfg_q.blank_flag_mode && !active_line && $stable(cfg_q)) |=>
			sync_pin_b_o == $past(cfg_q.pin_b_pol);
	endproperty
	a_cbn_vblank: assert property (p_cbn_vblank) else $error("pulse in vblank");

	property p_field_seq_sync_range;
		field_seq_sync_q < field_seq_sync_period || !$stable(mode_q) || $past(field_seq_sync_q) >= field_seq_sync_period;
	endproperty
	a_field_seq_sync_range: assert property (p_field_seq_sync_range) else $error("field sequence overrun");

	property p_bhold;
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule // video_sync_port_trigger

// ### tb/sync_source_model.sv
`timescale 1ns/1ps
module sync_source_model (
	input  wire logic aclk,
	input  wire logic pol_a,
	input  wire logic pol_b,
	input  wire logic fire_a,
	input  wire logic fire_b,
	output logic      drive_a,
	output logic      drive_b
);
	logic [3:0] cnt_a_q;
	logic [3:0] cnt_b_q;

	initial begin
		cnt_a_q = 4'h0;
		cnt_b_q = 4'h0;
	end

	// each request gives an active pulse eight clocks long
	always_ff @(posedge aclk) begin
		cnt_a_q <= fire_a ? 4'h8 : ((cnt_a_q != 4'h0) ? cnt_a_q - 4'h1 : 4'h0);
		cnt_b_q <= fire_b ? 4'h8 : ((cnt_b_q != 4'h0) ? cnt_b_q - 4'h1 : 4'h0);
	end

	// idle at the inactive level, active level low when polarity is set
	assign drive_a = (cnt_a_q != 4'h0) ^ pol_a;
	assign drive_b = (cnt_b_q != 4'h0) ^ pol_b;
endmodule // sync_source_model

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module tb;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        a_o, a_oe, b_o, b_oe, a_drv, b_drv, pol_a, pol_b, fire_a, fire_b;
	logic        hs, blank, odd, s_hs;
	int          miscompares;
	int          cmp_count;

	video_sync_port_trigger u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sync_pin_a_i(a_oe ? a_o : a_drv), .sync_pin_a_o(a_o), .sync_pin_a_oe(a_oe),
		.sync_pin_b_i(b_oe ? b_o : b_drv), .sync_pin_b_o(b_o), .sync_pin_b_oe(b_oe),
		.stream_hsync(s_hs), .stream_vsync(1'b0),
		.hsync_out(hs), .blank_out(blank), .odd_field_out(odd)
	);

	sync_source_model u_src (
		.aclk(aclk), .pol_a(pol_a), .pol_b(pol_b), .fire_a(fire_a), .fire_b(fire_b),
		.drive_a(a_drv), .drive_b(b_drv)
	);

	always #4 aclk = ~aclk;

	task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, ta, tw;
		int   n;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w) && n < 100) begin
			@(negedge aclk);
			ta = awready && !aw;
			tw = wready && !w;
			@(posedge aclk);
			if (ta) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (tw) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			n++;
		end
		bready <= 1'b1;
		do @(negedge aclk); while (!bvalid && ++n < 200);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready && ++n < 100);
		@(posedge aclk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge aclk); while (!rvalid && ++n < 200);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic set(input logic [7:0] idx, input logic [31:0] d);
		logic [1:0] r;
		wr(idx, d, r);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		`CHK(d, e)
		`CHK(r, er)
	endtask

	// cycles from the trigger request to the rise of hsync_out
	// src 0 pin A, 1 pin B, 2 embedded stream pulse
	task automatic trig(input logic [1:0] src, output int d);
		repeat (400) @(posedge aclk);
		if (src == 2'h2)
			s_hs <= 1'b1;
		else if (src[0])
			fire_b <= 1'b1;
		else
			fire_a <= 1'b1;
		@(posedge aclk);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
		s_hs <= 1'b0;
		d = 0;
		do begin
			@(negedge aclk);
			d++;
		end while (hs !== 1'b1 && d < 40);
		@(posedge aclk);
	endtask

	task automatic set_phase(input logic [7:0] p);
		set(vsync_pkg::IDX_HORIZ_TRIGGER_PHASE_LO, {24'h0, p});
		set(vsync_pkg::IDX_TRIG_HI, 32'h0);
	endtask

	task automatic count_b(output int ones);
		ones = 0;
		repeat (864) begin
			@(negedge aclk);
			ones += int'(b_o === 1'b1);
		end
		@(posedge aclk);
	endtask

	task automatic t_regs;
		logic [1:0] r;
		rchk(vsync_pkg::IDX_SYNC_CFG, 32'h0, vsync_pkg::RESP_OKAY);
		`CHK({a_oe, b_oe}, 2'h0)
		set(vsync_pkg::IDX_SYNC_CFG, 32'hFF);
		rchk(vsync_pkg::IDX_SYNC_CFG, 32'hFF, vsync_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK({a_oe, b_oe}, 2'h3)
		`CHK(a_o, 1'b1)
		set(vsync_pkg::IDX_HORIZ_TRIGGER_PHASE_LO, 32'hB0);
		set(vsync_pkg::IDX_TRIG_HI, 32'hDF);
		rchk(vsync_pkg::IDX_HORIZ_TRIGGER_PHASE_LO, 32'hB0, vsync_pkg::RESP_OKAY);
		rchk(vsync_pkg::IDX_TRIG_HI, 32'hDF, vsync_pkg::RESP_OKAY);
		wr(8'h7F, 32'hFF, r);
		`CHK(r, vsync_pkg::RESP_SLVERR)
		rchk(8'h7F, 32'h0, vsync_pkg::RESP_SLVERR);
		set(vsync_pkg::IDX_SYNC_CFG, 32'h0);
	endtask

	task automatic t_phase;
		int d0, d1, dx;
		set_phase(8'h4F);
		trig(2'h0, dx);
		trig(2'h0, d0);
		`CHK(d0 < 40, 1'b1)
		set_phase(8'h50);
		trig(2'h0, d1);
		`CHK(d1, d0)
		set_phase(8'h4E);
		trig(2'h0, d1);
		`CHK(d1, d0 + 1)
		set_phase(8'h4F);
		set(vsync_pkg::IDX_SYNC_CFG, 32'h08);
		pol_a <= 1'b1;
		trig(2'h0, dx);
		`CHK(dx, d0)
		set(vsync_pkg::IDX_SYNC_CFG, 32'h21);
		pol_b <= 1'b1;
		trig(2'h1, dx);
		`CHK(dx, d0)
		// stream pulse skips the source model's counter register and the two pin flip-flops
		set(vsync_pkg::IDX_VIDEO_MODE, 32'h02);
		set(vsync_pkg::IDX_SYNC_CFG, 32'h01);
		trig(2'h2, dx);
		`CHK(dx, d0 - 3)
		set(vsync_pkg::IDX_SYNC_CFG, 32'h21);
		trig(2'h1, dx);
		`CHK(dx, 40)
		set(vsync_pkg::IDX_VIDEO_MODE, 32'h00);
	endtask

	task automatic t_pin_b_out;
		int n0, n1;
		set(vsync_pkg::IDX_SYNC_CFG, 32'h02);
		repeat (3) @(posedge aclk);
		`CHK(b_oe, 1'b1)
		count_b(n0);
		`CHK(n0, int'(vsync_pkg::REF_STOP_RST - vsync_pkg::REF_START_RST) / 2)
		set(vsync_pkg::IDX_SYNC_CFG, 32'h03);
		repeat (3) @(posedge aclk);
		count_b(n1);
		`CHK(n1, 864 - n0)
	endtask

	task automatic t_vert;
		logic [31:0] d;
		logic [1:0]  r;
		int          n, dx;
		set(vsync_pkg::IDX_SYNC_CFG, 32'h08);
		set(vsync_pkg::IDX_TRIG_HI, 32'h05);
		trig(2'h0, dx);
		repeat (8) @(posedge aclk);
		rd(vsync_pkg::IDX_STATUS, d, r);
		`CHK(d[26:16], 11'h005)
		`CHK(odd, 1'b1)
		set(vsync_pkg::IDX_SYNC_CFG, 32'h0E);
		repeat (3) @(posedge aclk);
		count_b(n);
		`CHK(n, 0)
		`CHK(blank, 1'b1)
	endtask

	task automatic t_blank;
		int n;
		set(vsync_pkg::IDX_SYNC_CFG, 32'h05);
		repeat (4) @(posedge aclk);
		`CHK(blank, 1'b1)
		fire_b <= 1'b1;
		@(posedge aclk);
		fire_b <= 1'b0;
		n = 0;
		repeat (20) begin
			@(negedge aclk);
			n += int'(blank === 1'b0);
		end
		`CHK(n, 8)
	endtask

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{pol_a, pol_b, fire_a, fire_b, s_hs} = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_phase();
		t_pin_b_out();
		t_vert();
		t_blank();
		results();
	end

	initial begin
		#(8 * 30000);
		miscompares++;
		results();
	end
endmodule // tb
